// File: sbf_pkg.sv
// Constants shared by the shared byte FIFO block
package sbf_pkg;
    localparam int unsigned DEPTH_FULL   = 512;
    localparam int unsigned DEPTH_SMALL  = 255;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned PTR_W        = 9;
    localparam int unsigned CNT_W        = 10;
    localparam int unsigned THR_W        = 9;
    localparam int unsigned IDX_W        = 6;
    localparam int unsigned IRQ_W        = 3;

    localparam logic [CNT_W-1:0] CNT_FULL  = 10'h200;
    localparam logic [CNT_W-1:0] CNT_SMALL = 10'h0FF;
    localparam logic [CNT_W-1:0] CNT_ONE   = 10'h001;
    localparam logic [THR_W-1:0] THR_RST   = 9'h008;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] REG_DATA   = 6'h00;
    localparam logic [IDX_W-1:0] REG_COUNT  = 6'h01;
    localparam logic [IDX_W-1:0] REG_CTRL   = 6'h02;
    localparam logic [IDX_W-1:0] REG_THR    = 6'h03;
    localparam logic [IDX_W-1:0] REG_IRQ_ST = 6'h04;
    localparam logic [IDX_W-1:0] REG_IRQ_EN = 6'h05;

    // Fields of buffer_control_reg
    localparam int unsigned CTRL_CLEAR    = 0;
    localparam int unsigned CTRL_CAP_SEL  = 1;
    localparam int unsigned CTRL_THR_MSB  = 2;
    localparam int unsigned CTRL_CNT_LO   = 3;
    localparam int unsigned CTRL_CNT_HI   = 4;
    localparam int unsigned CTRL_NEAR_E   = 5;
    localparam int unsigned CTRL_NEAR_F   = 6;
    localparam int unsigned CTRL_OVF      = 7;

    // Fields of irq_status_first and irq_enable_first
    localparam int unsigned IRQ_NEAR_E = 0;
    localparam int unsigned IRQ_NEAR_F = 1;
    localparam int unsigned IRQ_ERR    = 2;
endpackage

// File: sbf_mem.sv
// Byte storage array with one write port and one combinational read port
module sbf_mem #(
    parameter int unsigned DW    = 8,
    parameter int unsigned AW    = 9,
    parameter int unsigned DEPTH = 512
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [DW-1:0] wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] mem_q [DEPTH];

    // No reset: stale bytes are unreachable once the pointers are cleared
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    assign rdata_o = mem_q[raddr_i];
endmodule

// File: sbf_fifo.sv
// Shared byte FIFO with watermark flags, interrupts and Wishbone registers
// Behaviour
// - One FIFO of 512 bytes
// - Capacity select limits depth to 255 bytes
// - Full mode count and watermark span two bytes
// - Host and state machine share one storage
// - Clear bit resets pointers and fill count
// - Write increments, read decrements fill count
// - Write when full sets overflow and error
// - Watermark nine bits: reg 2 bit 2, reg 3
// - Near full when free space <= watermark
// - Near empty when fill count <= watermark
// - Near empty rise raises interrupt when enabled
// - Near full rise raises interrupt when enabled
//
// Local design decision: the Wishbone register port.
module sbf_fifo
    import sbf_pkg::*;
#(
    parameter int unsigned DEPTH = DEPTH_FULL
) (
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    input  wire logic              sm_wr_i,
    input  wire logic [DATA_W-1:0] sm_wdata_i,
    input  wire logic              sm_rd_i,
    output logic      [DATA_W-1:0] sm_rdata_o,
    output logic                   sm_full_o,
    output logic                   sm_empty_o,
    output logic                   irq_o
);
    typedef struct packed {
        logic [PTR_W-1:0]  wr_ptr;
        logic [PTR_W-1:0]  rd_ptr;
        logic [CNT_W-1:0]  count;
        logic              cap_sel;
        logic [THR_W-1:0]  thr;
        logic              near_e;
        logic              near_f;
        logic              ovf;
        logic              full;
        logic              empty;
        logic [IRQ_W-1:0]  irq_st;
        logic [IRQ_W-1:0]  irq_en;
        logic              irq;
        logic              ack;
        logic [31:0]       dat;
        logic [DATA_W-1:0] sm_rdata;
    } sbf_state_s;

    localparam sbf_state_s RESET_S = '{
        wr_ptr:   '0,
        rd_ptr:   '0,
        count:    '0,
        cap_sel:  1'b0,
        thr:      THR_RST,
        near_e:   1'b1,
        near_f:   1'b0,
        ovf:      1'b0,
        full:     1'b0,
        empty:    1'b1,
        irq_st:   '0,
        irq_en:   '0,
        irq:      1'b0,
        ack:      1'b0,
        dat:      '0,
        sm_rdata: '0
    };

    sbf_state_s        q;
    sbf_state_s        d;
    logic [DATA_W-1:0] mem_rdata;
    logic              mem_we;
    logic [DATA_W-1:0] mem_wdata;

    sbf_mem #(
        .DW    (DATA_W),
        .AW    (PTR_W),
        .DEPTH (DEPTH)
    ) u_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .waddr_i (q.wr_ptr),
        .wdata_i (mem_wdata),
        .raddr_i (q.rd_ptr),
        .rdata_o (mem_rdata)
    );

    always_comb begin
        logic [IDX_W-1:0]  idx;
        logic              take;
        logic              push;
        logic              pop;
        logic              push_ok;
        logic              pop_ok;
        logic              clear;
        logic [CNT_W-1:0]  size;
        logic [CNT_W-1:0]  free;
        logic [CNT_W-1:0]  thr_eff;
        logic [IRQ_W-1:0]  irq_set;
        logic [IRQ_W-1:0]  irq_clr;
        idx       = adr_i[7:2];
        push      = 1'b0;
        pop       = 1'b0;
        clear     = 1'b0;
        irq_clr   = '0;
        mem_wdata = sm_wdata_i;
        d         = q;
        d.ack     = 1'b0;
        // State machine wins the cycle; the host access waits until both sm_wr_i and sm_rd_i are low
        take = cyc_i & stb_i & ~q.ack & ~sm_wr_i & ~sm_rd_i;
        if (sm_wr_i) begin
            push = 1'b1;
        end
        if (sm_rd_i) begin
            pop = 1'b1;
        end
        if (take) begin
            d.ack = 1'b1;
            d.dat = '0;
            if (we_i) begin
                if (sel_i[0]) begin
                    unique case (idx)
                        REG_DATA: begin
                            push      = 1'b1;
                            mem_wdata = dat_i[DATA_W-1:0];
                        end
                        REG_CTRL: begin
                            clear     = dat_i[CTRL_CLEAR];
                            d.cap_sel = dat_i[CTRL_CAP_SEL];
                            d.thr[THR_W-1] = dat_i[CTRL_THR_MSB];
                        end
                        REG_THR: begin
                            d.thr[7:0] = dat_i[7:0];
                        end
                        REG_IRQ_ST: begin
                            irq_clr = dat_i[IRQ_W-1:0];
                        end
                        REG_IRQ_EN: begin
                            d.irq_en = dat_i[IRQ_W-1:0];
                        end
                        default: begin
                        end
                    endcase
                end
            end else begin
                unique case (idx)
                    REG_DATA: begin
                        // Empty read returns zero and leaves count alone
                        pop   = 1'b1;
                        d.dat = q.empty ? '0 : {24'h000000, mem_rdata};
                    end
                    REG_COUNT: begin
                        d.dat[7:0] = q.count[7:0];
                    end
                    REG_CTRL: begin
                        d.dat[CTRL_CAP_SEL] = q.cap_sel;
                        d.dat[CTRL_THR_MSB] = q.thr[THR_W-1];
                        d.dat[CTRL_CNT_LO]  = q.count[8];
                        d.dat[CTRL_CNT_HI]  = q.count[9];
                        d.dat[CTRL_NEAR_E]  = q.near_e;
                        d.dat[CTRL_NEAR_F]  = q.near_f;
                        d.dat[CTRL_OVF]     = q.ovf;
                    end
                    REG_THR: begin
                        d.dat[7:0] = q.thr[7:0];
                    end
                    REG_IRQ_ST: begin
                        d.dat[IRQ_W-1:0] = q.irq_st;
                    end
                    REG_IRQ_EN: begin
                        d.dat[IRQ_W-1:0] = q.irq_en;
                    end
                    default: begin
                    end
                endcase
            end
        end

        push_ok = push & ~q.full;
        pop_ok  = pop & ~q.empty;
        mem_we  = push_ok;
        if (push_ok) begin
            d.wr_ptr = q.wr_ptr + PTR_W'(1);
        end
        if (pop_ok) begin
            d.rd_ptr     = q.rd_ptr + PTR_W'(1);
            d.sm_rdata   = sm_rd_i ? mem_rdata : q.sm_rdata;
        end
        d.count = q.count + (push_ok ? CNT_ONE : '0) - (pop_ok ? CNT_ONE : '0);
        irq_set = '0;
        if (push & q.full) begin
            d.ovf = 1'b1;
            irq_set[IRQ_ERR] = 1'b1;
        end
        if (clear) begin
            d.wr_ptr = '0;
            d.rd_ptr = '0;
            d.count  = '0;
            d.ovf    = 1'b0;
        end

        // Small mode uses only the low byte of the watermark
        size    = d.cap_sel ? CNT_SMALL : CNT_FULL;
        thr_eff = d.cap_sel ? {2'b00, d.thr[7:0]} : {1'b0, d.thr};
        // A count left above a shrunk capacity reads as no free space
        free     = (d.count >= size) ? '0 : size - d.count;
        d.full   = d.count >= size;
        d.empty  = d.count == '0;
        d.near_f = free <= thr_eff;
        d.near_e = d.count <= thr_eff;
        irq_set[IRQ_NEAR_E] = d.near_e & ~q.near_e;
        irq_set[IRQ_NEAR_F] = d.near_f & ~q.near_f;
        // Set wins over a write-one clear in the same cycle
        d.irq_st = (q.irq_st & ~irq_clr) | irq_set;
        d.irq    = |(d.irq_st & d.irq_en);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= RESET_S;
        end else begin
            q <= d;
        end
    end

    assign dat_o      = q.dat;
    assign ack_o      = q.ack;
    assign sm_rdata_o = q.sm_rdata;
    assign sm_full_o  = q.full;
    assign sm_empty_o = q.empty;
    assign irq_o      = q.irq;
endmodule

// File: sbf_chk.sv
// Port assertions of the shared byte FIFO
module sbf_chk
    import sbf_pkg::*;
#(parameter int unsigned DEPTH = DEPTH_FULL) (
    input wire logic              clk_i, rst_i, cyc_i, stb_i, we_i,
    input wire logic [7:0]        adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [31:0]       dat_i, dat_o,
    input wire logic              ack_o, sm_wr_i, sm_rd_i, sm_full_o,
    input wire logic              sm_empty_o, irq_o,
    input wire logic [DATA_W-1:0] sm_wdata_i, sm_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Host cycles are held off while the state machine strobes
    wire logic req = cyc_i && stb_i && !ack_o && !sm_wr_i && !sm_rd_i;
    property p_ack; req |=> ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack missing");
    property p_pulse; ack_o |=> !ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long");
    property p_idle; !(cyc_i && stb_i) |=> !ack_o; endproperty
    a_idle: assert property (p_idle) else $error("stray ack");
    property p_push; sm_wr_i && !sm_rd_i |=> !sm_empty_o; endproperty
    a_push: assert property (p_push) else $error("push lost");
    property p_nopop; sm_empty_o && sm_rd_i && !sm_wr_i |=> sm_empty_o;
    endproperty
    a_nopop: assert property (p_nopop) else $error("empty pop");
    property p_keep; sm_full_o && sm_wr_i && !sm_rd_i |=> sm_full_o;
    endproperty
    a_keep: assert property (p_keep) else $error("full push");
    property p_flags; sm_full_o |-> !sm_empty_o; endproperty
    a_flags: assert property (p_flags) else $error("full and empty");
    property p_hold; !sm_rd_i |=> $stable(sm_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("pop data moved");
endmodule

// File: sbf_sm_model.sv
// State machine side model: pushes and pops bytes on command
module sbf_sm_model
    import sbf_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic [DATA_W-1:0] rdata_i,
    output logic                   wr_o,
    output logic                   rd_o,
    output logic      [DATA_W-1:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'hA5;
    end
    // Pushes base+i; slow leaves an idle cycle with scrambled data
    task automatic push(input int n, input logic [7:0] base, input bit slow);
        for (int i = 0; i < n; i++) begin
            wr_o <= 1'b1;
            wdata_o <= base + i[7:0];
            @(posedge clk_i);
            if (slow) begin
                wr_o <= 1'b0;
                wdata_o <= ~wdata_o;
                @(posedge clk_i);
            end
        end
        wr_o <= 1'b0;
        wdata_o <= ~wdata_o;
    endtask
    task automatic pop(output logic [7:0] b);
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(posedge clk_i);
        b = rdata_i;
    endtask
endmodule

// File: sbf_fifo_tb.sv
// Self-checking bench of the shared byte FIFO
module sbf_fifo_tb
    import sbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, ack_o, sm_wr_i, sm_rd_i, irq_o;
    logic        sm_full_o, sm_empty_o;
    logic [7:0]  adr_i = 8'h00, r, d, sm_wdata_i, sm_rdata_o, q[$];
    logic [3:0]  sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o;
    int          n_fail = 0, checks = 0, num, seed = 32'h83D0C84D;
    sbf_fifo #(.DEPTH(DEPTH_FULL)) sbf_fifo_i (.clk_i, .rst_i, .cyc_i, .stb_i,
        .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sm_wr_i, .sm_wdata_i,
        .sm_rd_i, .sm_rdata_o, .sm_full_o, .sm_empty_o, .irq_o);
    sbf_sm_model sbf_sm_model_i (.clk_i, .rdata_i(sm_rdata_o), .wr_o(sm_wr_i),
        .rd_o(sm_rd_i), .wdata_o(sm_wdata_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // Whole sequence needs about 1300 cycles
    initial begin
        #100us;
        n_fail++;
        final_report();
    end
    task automatic chk(input string nm, input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    function automatic logic [7:0] cexp(int c, int t, bit cap, bit ovf);
        int sz;
        sz = cap ? 255 : 512;
        return {ovf, (sz - c) <= t, c <= t, c[9], c[8], t[8], cap, 1'b0};
    endfunction
    // Hang is caught by the watchdog, not here
    task automatic wb(bit w, logic [5:0] ix, logic [7:0] v);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {ix, 2'b00};
        dat_i <= {24'h0, v};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        r = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rchk(logic [5:0] ix, string nm, logic [7:0] e);
        wb(0, ix, 8'h00);
        chk(nm, r, e);
    endtask
    task automatic final_report();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rchk(REG_CTRL, "ctrl", cexp(0, 8, 0, 0));
        rchk(REG_THR, "thr", 8'h08);
        wb(1, REG_IRQ_EN, 8'h07);
        // Above the reset watermark so that draining raises near-empty
        num = 9 + ($unsigned($random(seed)) % 23);
        for (int i = 0; i < num; i++) begin
            d = $random(seed);
            q.push_back(d);
            wb(1, REG_DATA, d);
        end
        rchk(REG_COUNT, "count", num[7:0]);
        for (int i = 0; i < num / 2; i++) begin
            sbf_sm_model_i.pop(d);
            chk("sm_data", d, q.pop_front());
        end
        while (q.size() > 0) begin
            wb(0, REG_DATA, 8'h00);
            chk("host_data", r, q.pop_front());
        end
        sbf_sm_model_i.pop(d);
        rchk(REG_COUNT, "count", 8'h00);
        rchk(REG_DATA, "empty_rd", 8'h00);
        rchk(REG_COUNT, "count", 8'h00);
        chk("irq", irq_o, 1);
        wb(1, REG_IRQ_ST, 8'h07);
        chk("irq", irq_o, 0);
        wb(1, REG_CTRL, 8'h02);
        sbf_sm_model_i.push(256, 8'h10, 1'b0);
        rchk(REG_CTRL, "ctrl", cexp(255, 8, 1, 1));
        rchk(REG_COUNT, "count", 8'hFF);
        rchk(REG_IRQ_ST, "irq_st", 8'h06);
        rchk(REG_DATA, "first", 8'h10);
        wb(1, REG_CTRL, 8'h01);
        rchk(REG_CTRL, "ctrl", cexp(0, 8, 0, 0));
        rchk(REG_IRQ_ST, "irq_st", 8'h07);
        wb(1, REG_IRQ_ST, 8'h07);
        wb(1, REG_IRQ_EN, 8'h02);
        wb(1, REG_CTRL, 8'h04);
        sbf_sm_model_i.push(300, 8'h00, 1'b1);
        rchk(REG_CTRL, "ctrl", cexp(300, 264, 0, 0));
        rchk(REG_COUNT, "count", 8'h2C);
        chk("irq", irq_o, 1);
        wb(1, REG_IRQ_EN, 8'h00);
        chk("irq", irq_o, 0);
        sbf_sm_model_i.push(212, 8'h00, 1'b0);
        @(posedge clk_i);
        chk("full", sm_full_o, 1);
        wb(1, REG_DATA, 8'h5A);
        rchk(REG_CTRL, "ctrl", cexp(512, 264, 0, 1));
        final_report();
    end
endmodule
bind sbf_fifo sbf_chk #(.DEPTH(DEPTH)) sbf_chk_i (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .sm_wr_i,
    .sm_rd_i, .sm_full_o, .sm_empty_o, .irq_o, .sm_wdata_i, .sm_rdata_o);
